// [src/flash_ctrl.sv]
// Program flash controller with remote programming entry and protection
`timescale 1ns/100ps
`include "flash_ctrl_map.svh"
module flash_ctrl (
	// System
	input wire logic sys_clk,
	input wire logic arst_n,
	// Programming link
	input wire logic remote_prog_serial_clock,
	input wire logic remote_prog_serial_data,
	input wire logic remote_prog_select_pin,
	// Option bit
	input wire logic protect_option,
	// CPU fetch port
	input wire logic cpu_rd,
	input wire logic [15:0] cpu_addr,
	output logic [7:0] cpu_rdata_reg,
	output logic cpu_rvalid_reg,
	// Status
	output flash_ctrl_pkg::isp_state_type state_reg,
	output logic [15:0] boot_vector_reg,
	output logic busy_reg,
	output logic read_blocked_reg,
	output logic [7:0] tool_rdata_reg
);
	import flash_ctrl_pkg::*;

	////////////////////////////////////////////////////////////////////////
	function automatic logic in_flash(input logic [15:0] a);
		in_flash = (a >= `FLASH_BASE_ADDR);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Synchronisers for pins and link word toggle
	logic sel_s1, sel_s2, sel_s3;
	logic prot_s1, prot_s2, prot_s3;
	logic tgl_s1, tgl_s2, tgl_s3;
	logic link_en_s1, link_en_s2;
	logic [7:0] link_word;
	logic link_tgl;
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			{sel_s1, sel_s2, sel_s3} <= 3'h0;
			{prot_s1, prot_s2, prot_s3} <= 3'h0;
			{tgl_s1, tgl_s2, tgl_s3} <= 3'h0;
		end else begin
			{sel_s1, sel_s2, sel_s3} <= {remote_prog_select_pin, sel_s1, sel_s2};
			{prot_s1, prot_s2, prot_s3} <= {protect_option, prot_s1, prot_s2};
			{tgl_s1, tgl_s2, tgl_s3} <= {link_tgl, tgl_s1, tgl_s2};
		end
	end
	wire sel_rise = sel_s2 & ~sel_s3;
	wire prot_fall = ~prot_s2 & prot_s3;
	wire word_evt = tgl_s2 ^ tgl_s3;

	////////////////////////////////////////////////////////////////////////
	// Link domain: receiver runs only past RAM select
	wire link_active = (state_reg == ST_DOWNLOAD) || (state_reg == ST_RUN);
	always_ff @(posedge remote_prog_serial_clock or negedge arst_n) begin
		if (!arst_n) begin
			link_en_s1 <= 1'b0;
			link_en_s2 <= 1'b0;
		end else begin
			link_en_s1 <= link_active;
			link_en_s2 <= link_en_s1;
		end
	end
	serial_link_rx u_rx (
		.link_clk(remote_prog_serial_clock),
		.link_rst_n(arst_n),
		.serial_data(remote_prog_serial_data),
		.enable(link_en_s2),
		.word_reg(link_word),
		.word_tgl_reg(link_tgl)
	);

	////////////////////////////////////////////////////////////////////////
	// Entry window after reset release
	logic [15:0] win_reg;
	logic [3:0] pulse_reg;
	wire win_open = (win_reg != `ENTRY_WINDOW);
	wire entry_ok = (pulse_reg == `ENTRY_PULSES);

	// Command decoder: byte stream is cmd, addr hi, addr lo, data; PROG is the command byte alone
	logic [1:0] phase_reg;
	logic [7:0] cmd_reg;
	logic [15:0] addr_reg;
	logic [7:0] row_data_reg [0:`ROW_BYTES-1];
	logic [`ROW_BYTES-1:0] row_vld_reg;
	logic [`FLASH_ADDR_W-5:0] row_addr_reg;
	logic [3:0] prog_idx_reg;
	logic [15:0] timer_reg;
	logic [`FLASH_ADDR_W-1:0] erase_addr_reg;
	logic fetch_pending_reg;

	wire cmd_done = word_evt && (phase_reg == 2'h3);
	wire is_load = cmd_done && (cmd_reg == `CMD_LOAD);
	wire is_prog = word_evt && (phase_reg == 2'h0) && (link_word == `CMD_PROG);
	wire is_read = cmd_done && (cmd_reg == `CMD_READ);
	wire wr_locked = prot_s2;
	wire prog_go = is_prog && (state_reg == ST_RUN) && !busy_reg && !wr_locked;
	wire prog_last = (prog_idx_reg == 4'hF);
	wire erase_last = (erase_addr_reg == `FLASH_ADDR_W'(`FLASH_DEPTH - 1));

	// Boot fetch and tool read sequencing
	logic [1:0] vec_step_reg;
	logic read_pend_reg;
	logic hit_d_reg;
	wire [`FLASH_ADDR_W-1:0] vec_base = `FLASH_ADDR_W'(`RESET_VEC_ADDR);
	// High byte at even address, low byte at the odd one after it
	wire [`FLASH_ADDR_W-1:0] vec_addr = {vec_base[`FLASH_ADDR_W-1:1],
		vec_step_reg[0]};

	////////////////////////////////////////////////////////////////////////
	// Array access mux
	logic arr_wr;
	logic [`FLASH_ADDR_W-1:0] arr_waddr, arr_raddr;
	logic [7:0] arr_wdata, arr_rdata;
	assign arr_wr = (state_reg == ST_ERASE) ||
		(busy_reg && (timer_reg == 16'h0000) && row_vld_reg[prog_idx_reg]);
	assign arr_waddr = (state_reg == ST_ERASE) ? erase_addr_reg :
		{row_addr_reg, prog_idx_reg};
	assign arr_wdata = (state_reg == ST_ERASE) ? `FLASH_ERASED :
		row_data_reg[prog_idx_reg];
	// Tool read wins; boot fetch never runs while the link is in use
	assign arr_raddr = is_read ? addr_reg[`FLASH_ADDR_W-1:0] :
		(fetch_pending_reg ? vec_addr :
		cpu_addr[`FLASH_ADDR_W-1:0]);

	flash_array u_array (
		.sys_clk(sys_clk),
		.wr_en(arr_wr),
		.wr_addr(arr_waddr),
		.wr_data(arr_wdata),
		.rd_addr(arr_raddr),
		.rd_data(arr_rdata)
	);

	////////////////////////////////////////////////////////////////////////
	// Phase sequencer
	isp_state_type state_next;
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_NORMAL: begin
				if (prot_fall) begin
					state_next = ST_ERASE;
				end else if (win_open && entry_ok) begin
					state_next = ST_RAM_SEL;
				end
			end
			ST_RAM_SEL: state_next = ST_DOWNLOAD;
			ST_DOWNLOAD: begin
				if (word_evt && (phase_reg == 2'h0) && (link_word == 8'h00)) begin
					state_next = ST_RUN;
				end
			end
			ST_RUN: begin
				if (prot_fall) begin
					state_next = ST_ERASE;
				end
			end
			ST_ERASE: begin
				if (erase_last) begin
					state_next = ST_NORMAL;
				end
			end
			default: state_next = ST_NORMAL;
		endcase
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_reg <= ST_NORMAL;
			win_reg <= 16'h0000;
			pulse_reg <= 4'h0;
			erase_addr_reg <= '0;
			read_blocked_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			if (win_open) begin
				win_reg <= win_reg + 16'h0001;
			end
			if (win_open && sel_rise && !entry_ok) begin
				pulse_reg <= pulse_reg + 4'h1;
			end
			if (state_reg == ST_ERASE) begin
				erase_addr_reg <= erase_addr_reg + `FLASH_ADDR_W'(1);
			end
			// Old data stays hidden until erase finishes
			read_blocked_reg <= prot_s2 || (state_next == ST_ERASE);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Stream decode and row latches
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			phase_reg <= 2'h0;
			cmd_reg <= 8'h00;
			addr_reg <= 16'h0000;
			row_vld_reg <= '0;
			row_addr_reg <= '0;
			tool_rdata_reg <= 8'h00;
			read_pend_reg <= 1'b0;
		end else begin
			// Array read data is registered, so take it one cycle later
			read_pend_reg <= is_read;
			if (word_evt && state_reg == ST_RUN) begin
				phase_reg <= (is_prog ? 2'h0 : phase_reg + 2'h1);
				if (phase_reg == 2'h0) begin
					cmd_reg <= link_word;
				end
				if (phase_reg == 2'h1) begin
					addr_reg[15:8] <= link_word;
				end
				if (phase_reg == 2'h2) begin
					addr_reg[7:0] <= link_word;
				end
			end
			// Latch bytes of one 16-byte row; row is last address seen
			if (is_load && state_reg == ST_RUN && !busy_reg && !wr_locked) begin
				row_data_reg[addr_reg[3:0]] <= link_word;
				row_vld_reg[addr_reg[3:0]] <= 1'b1;
				row_addr_reg <= addr_reg[`FLASH_ADDR_W-1:4];
			end
			if (busy_reg && prog_last && timer_reg == 16'h0000) begin
				row_vld_reg <= '0;
			end
			if (read_pend_reg) begin
				tool_rdata_reg <= read_blocked_reg ? 8'h00 : arr_rdata;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Programming cycle, one byte per timed step
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			busy_reg <= 1'b0;
			prog_idx_reg <= 4'h0;
			timer_reg <= 16'h0000;
		end else if (prog_go) begin
			busy_reg <= 1'b1;
			prog_idx_reg <= 4'h0;
			timer_reg <= 16'(`PROG_CYCLES);
		end else if (busy_reg) begin
			if (timer_reg != 16'h0000) begin
				timer_reg <= timer_reg - 16'h0001;
			end else if (prog_last) begin
				busy_reg <= 1'b0;
			end else begin
				prog_idx_reg <= prog_idx_reg + 4'h1;
				timer_reg <= 16'(`PROG_CYCLES);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// CPU reads and boot vector fetch
	wire cpu_hit = cpu_rd && in_flash(cpu_addr) && !fetch_pending_reg;
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			fetch_pending_reg <= 1'b1;
			vec_step_reg <= 2'h0;
			boot_vector_reg <= 16'h0000;
			cpu_rdata_reg <= 8'h00;
			cpu_rvalid_reg <= 1'b0;
			hit_d_reg <= 1'b0;
		end else begin
			// Vector high byte read first at FFFE, low follows one cycle
			if (fetch_pending_reg && !win_open && !entry_ok) begin
				vec_step_reg <= vec_step_reg + 2'h1;
				if (vec_step_reg == 2'h1) begin
					boot_vector_reg[15:8] <= arr_rdata;
				end
				if (vec_step_reg == 2'h2) begin
					boot_vector_reg[7:0] <= arr_rdata;
					fetch_pending_reg <= 1'b0;
				end
			end
			// Valid delayed to line up with the registered array data
			hit_d_reg <= cpu_hit && (state_reg == ST_NORMAL);
			cpu_rvalid_reg <= hit_d_reg;
			cpu_rdata_reg <= arr_rdata;
		end
	end
endmodule

// [src/flash_ctrl_map.svh]
// Constants for the program flash controller: map, timing, entry code
`ifndef FLASH_CTRL_MAP_SVH
`define FLASH_CTRL_MAP_SVH
`define FLASH_BASE_ADDR 16'hF000
`define FLASH_ADDR_W 12
`define FLASH_DEPTH 4096
`define FLASH_ERASED 8'hFF
`define ROW_BYTES 16
`define RESET_VEC_ADDR 16'hFFFE
`define ENTRY_PULSES 4'h4
`define ENTRY_WINDOW 16'h0800
`define PROG_TIME_US 5
`define PROG_CYCLES ((`PROG_TIME_US * 25 + 0) > 0 ? (`PROG_TIME_US * 25) : 1)
`define CMD_LOAD 8'h01
`define CMD_PROG 8'h02
`define CMD_READ 8'h03
`endif

// [src/flash_ctrl_pkg.sv]
// Types for the program flash controller
package flash_ctrl_pkg;
	typedef enum logic [4:0] {
		ST_NORMAL = 5'h01,
		ST_RAM_SEL = 5'h02,
		ST_DOWNLOAD = 5'h04,
		ST_RUN = 5'h08,
		ST_ERASE = 5'h10
	} isp_state_type;
endpackage

// [src/flash_array.sv]
// Byte-wide flash storage with registered read data
`timescale 1ns/100ps
`include "flash_ctrl_map.svh"
module flash_array (
	// Clock
	input wire logic sys_clk,
	// Access
	input wire logic wr_en,
	input wire logic [`FLASH_ADDR_W-1:0] wr_addr,
	input wire logic [7:0] wr_data,
	input wire logic [`FLASH_ADDR_W-1:0] rd_addr,
	output logic [7:0] rd_data
);
	logic [7:0] mem [0:`FLASH_DEPTH-1];
	always_ff @(posedge sys_clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		rd_data <= mem[rd_addr];
	end
endmodule

// [src/serial_link_rx.sv]
// Serial receiver on the programming link clock, toggle handshake out
`timescale 1ns/100ps
module serial_link_rx (
	// Link side
	input wire logic link_clk,
	input wire logic link_rst_n,
	input wire logic serial_data,
	input wire logic enable,
	// Word out, link domain
	output logic [7:0] word_reg,
	output logic word_tgl_reg
);
	logic [7:0] shift_reg;
	logic [2:0] cnt_reg;
	wire last_bit = (cnt_reg == 3'h7);
	always_ff @(posedge link_clk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			shift_reg <= 8'h00;
			cnt_reg <= 3'h0;
			word_reg <= 8'h00;
			word_tgl_reg <= 1'b0;
		end else if (enable) begin
			shift_reg <= {shift_reg[6:0], serial_data};
			cnt_reg <= cnt_reg + 3'h1;
			if (last_bit) begin
				// Word held stable until next toggle, safe to sample
				word_reg <= {shift_reg[6:0], serial_data};
				word_tgl_reg <= ~word_tgl_reg;
			end
		end
	end
endmodule

// [tb/flash_ctrl_checker.sv]
// Assertion checker for the program flash controller
`timescale 1ns/100ps
module flash_ctrl_checker (
	// System
	input wire logic sys_clk,
	input wire logic arst_n,
	// Inputs
	input wire logic protect_option,
	input wire logic cpu_rd,
	input wire logic [15:0] cpu_addr,
	// Outputs
	input wire logic cpu_rvalid_reg,
	input wire flash_ctrl_pkg::isp_state_type state_reg,
	input wire logic busy_reg,
	input wire logic read_blocked_reg,
	input wire logic [7:0] tool_rdata_reg
);
	import flash_ctrl_pkg::*;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	wire fl_rd = cpu_rd && cpu_addr >= 16'hF000;
	sequence s_erase;
		state_reg == ST_ERASE && read_blocked_reg;
	endsequence
	// Sixteen steps of 126 cycles; too long for a delay range
	sequence s_prog;
		busy_reg[*8];
	endsequence
	logic [11:0] busy_cnt;
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			busy_cnt <= 12'h000;
		end else begin
			busy_cnt <= busy_reg ? busy_cnt + 12'h001 : 12'h000;
		end
	end
	AST_RST_STATE:
	assert property ($rose(arst_n) |-> state_reg == ST_NORMAL) else $error("bad state");
	AST_CPU_LAT:
	assert property (fl_rd && state_reg == ST_NORMAL && !read_blocked_reg
		|-> ##[1:2] cpu_rvalid_reg) else $error("no read data");
	AST_ENTRY:
	assert property ($changed(state_reg) && state_reg == ST_RAM_SEL
		|-> $past(state_reg) == ST_NORMAL) else $error("bad entry");
	AST_SEL_DL:
	assert property (state_reg == ST_RAM_SEL |=> state_reg == ST_DOWNLOAD)
		else $error("bad phase");
	AST_PROG_LEN:
	assert property ($rose(busy_reg) |-> s_prog) else $error("bad busy");
	AST_PROG_CNT:
	assert property ($fell(busy_reg) |-> busy_cnt == 12'h7E0)
		else $error("bad busy length");
	AST_NO_REWRITE:
	assert property ($rose(busy_reg) |-> state_reg == ST_RUN && !read_blocked_reg)
		else $error("rewrite");
	AST_BLOCK_RD:
	assert property (read_blocked_reg && $changed(tool_rdata_reg)
		|-> tool_rdata_reg == 8'h00) else $error("read leak");
	AST_ERASE:
	assert property ($fell(protect_option) |-> ##[1:4] s_erase)
		else $error("no erase");
endmodule
bind flash_ctrl flash_ctrl_checker chk (.sys_clk, .arst_n, .protect_option,
	.cpu_rd, .cpu_addr, .cpu_rvalid_reg, .state_reg, .busy_reg,
	.read_blocked_reg, .tool_rdata_reg);

// [tb/prog_tool_model.sv]
// Programming tool model on the serial link and select pin
`timescale 1ns/100ps
module prog_tool_model (
	// Link pins
	output logic remote_prog_serial_clock,
	output logic remote_prog_serial_data,
	output logic remote_prog_select_pin
);
	initial begin
		remote_prog_serial_clock = 1'b0;
		remote_prog_serial_data = 1'b1;
		remote_prog_select_pin = 1'b0;
	end
	// Pulses long enough to pass the two-flop sync
	task automatic enter();
		repeat (4) begin
			#230 remote_prog_select_pin = 1'b1;
			#230 remote_prog_select_pin = 1'b0;
		end
	endtask
	// Two idle clocks let the receiver enable cross into the link domain
	task automatic wake();
		repeat (2) begin
			#80 remote_prog_serial_clock = 1'b1;
			#80 remote_prog_serial_clock = 1'b0;
		end
		#300;
	endtask
	// Clock stands low between frames; data idles inverted
	task automatic send_byte(input logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			remote_prog_serial_data = b[i];
			#80 remote_prog_serial_clock = 1'b1;
			#80 remote_prog_serial_clock = 1'b0;
		end
		remote_prog_serial_data = ~b[0];
		#300;
	endtask
endmodule

// [tb/tb_flash_ctrl.sv]
// Self-checking bench for the program flash controller
`timescale 1ns/100ps
`include "flash_ctrl_map.svh"
module tb_flash_ctrl;
	import flash_ctrl_pkg::*;
	logic sys_clk = 1'b0;
	logic arst_n = 1'b1;
	logic protect_option = 1'b0;
	logic cpu_rd = 1'b0;
	logic [15:0] cpu_addr = 16'h0000;
	logic remote_prog_serial_clock, remote_prog_serial_data;
	logic remote_prog_select_pin, cpu_rvalid_reg, busy_reg, read_blocked_reg;
	logic [7:0] cpu_rdata_reg, tool_rdata_reg;
	logic [15:0] boot_vector_reg;
	isp_state_type state_reg;
	int miscompares = 0;
	int n_checks = 0;
	int cyc = 0;
	// Address and byte; all in one row, as one cycle programs one row
	logic [23:0] rows [3] = '{24'hFFF0A5, 24'hFFFE12, 24'hFFFF34};
	always #20 sys_clk = ~sys_clk;
	prog_tool_model tool (.remote_prog_serial_clock, .remote_prog_serial_data,
		.remote_prog_select_pin);
	flash_ctrl dut (.sys_clk, .arst_n, .remote_prog_serial_clock,
		.remote_prog_serial_data, .remote_prog_select_pin, .protect_option,
		.cpu_rd, .cpu_addr, .cpu_rdata_reg, .cpu_rvalid_reg, .state_reg,
		.boot_vector_reg, .busy_reg, .read_blocked_reg, .tool_rdata_reg);
	task automatic cmp(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			$display("wrong value %0t seen %h exp %h", $time, seen, exp);
			miscompares++;
		end
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic wait_state(input isp_state_type st);
		for (int k = 0; k < 6000 && state_reg !== st; k++) @(negedge sys_clk);
		cmp(state_reg, st);
	endtask
	// Command, address high, address low, data
	task automatic cmd(input logic [7:0] c, input logic [15:0] a,
		input logic [7:0] d);
		tool.send_byte(c);
		tool.send_byte(a[15:8]);
		tool.send_byte(a[7:0]);
		tool.send_byte(d);
		repeat (20) @(negedge sys_clk);
	endtask
	task automatic cpu_read(input logic [15:0] a, input logic [7:0] e);
		@(posedge sys_clk);
		cpu_rd <= 1'b1;
		cpu_addr <= a;
		@(posedge sys_clk);
		cpu_rd <= 1'b0;
		@(negedge sys_clk);
		for (int k = 0; k < 4 && cpu_rvalid_reg !== 1'b1; k++) @(negedge sys_clk);
		cmp(cpu_rvalid_reg, 1'b1);
		cmp(cpu_rdata_reg, e);
	endtask
	// Run needs about 9700 cycles
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			miscompares++;
			final_report();
		end
	end
	initial begin
		arst_n <= 1'b0;
		repeat (6) @(negedge sys_clk);
		cmp(state_reg, ST_NORMAL);
		cmp(busy_reg, 1'b0);
		@(posedge sys_clk);
		arst_n <= 1'b1;
		$display("test reset done");
		tool.enter();
		wait_state(ST_DOWNLOAD);
		tool.wake();
		tool.send_byte(8'h00);
		wait_state(ST_RUN);
		foreach (rows[i]) cmd(`CMD_LOAD, rows[i][23:8], rows[i][7:0]);
		tool.send_byte(`CMD_PROG);
		repeat (10) @(negedge sys_clk);
		cmp(busy_reg, 1'b1);
		for (int k = 0; k < 3000 && busy_reg !== 1'b0; k++) @(negedge sys_clk);
		cmp(busy_reg, 1'b0);
		foreach (rows[i]) begin
			cmd(`CMD_READ, rows[i][23:8], 8'h00);
			cmp(tool_rdata_reg, rows[i][7:0]);
		end
		$display("test programming done");
		@(posedge sys_clk);
		protect_option <= 1'b1;
		cmd(`CMD_READ, 16'hFFFE, 8'h00);
		cmp(tool_rdata_reg, 8'h00);
		tool.send_byte(`CMD_PROG);
		repeat (10) @(negedge sys_clk);
		cmp(busy_reg, 1'b0);
		@(posedge sys_clk);
		protect_option <= 1'b0;
		repeat (6) @(negedge sys_clk);
		cmp(state_reg, ST_ERASE);
		cmp(read_blocked_reg, 1'b1);
		wait_state(ST_NORMAL);
		$display("test protection done");
		@(posedge sys_clk);
		arst_n <= 1'b0;
		repeat (6) @(posedge sys_clk);
		arst_n <= 1'b1;
		repeat (2100) @(negedge sys_clk);
		cmp(boot_vector_reg, 16'hFFFF);
		cmp(state_reg, ST_NORMAL);
		cpu_read(16'hFFFE, 8'hFF);
		cpu_read(16'hF000, 8'hFF);
		$display("test boot done");
		final_report();
	end
endmodule
